// file: core/ect_pkg.sv
// constants for the echo canceller tuning register bank
// assumes a 32-bit AXI4-Lite slave, one byte register per aligned word
//
// Contract
// - double-talk threshold of each canceller resets to 4800h, about 0.5625.
// - double-talk threshold at most 7FFFh; high byte second, low first.
// - suppressor threshold of each canceller resets to 0B60h, about 0.0889.
// - suppressor threshold is 16 bits; high byte 0Bh second, low 60h first.
// - step size is a 16-bit two's complement value per canceller, writable.
// - step size resets to 4000h, meaning 1.0; bytes 40h and 00h.
// - canceller A step size high byte at index 1Bh, low at 1Ah.
// - canceller B step size is independent, high at 3Bh, low at 3Ah.
// - the second step size register holds the top eight bits.
package ect_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] ECT_IDX_A_DT_LO = 8'h14;
  localparam logic [7:0] ECT_IDX_A_DT_HI = 8'h15;
  localparam logic [7:0] ECT_IDX_A_SUP_LO = 8'h16;
  localparam logic [7:0] ECT_IDX_A_SUP_HI = 8'h17;
  localparam logic [7:0] ECT_IDX_A_MU_LO = 8'h1a;
  localparam logic [7:0] ECT_IDX_A_MU_HI = 8'h1b;
  localparam logic [7:0] ECT_IDX_B_DT_LO = 8'h34;
  localparam logic [7:0] ECT_IDX_B_DT_HI = 8'h35;
  localparam logic [7:0] ECT_IDX_B_SUP_LO = 8'h36;
  localparam logic [7:0] ECT_IDX_B_SUP_HI = 8'h37;
  localparam logic [7:0] ECT_IDX_B_MU_LO = 8'h3a;
  localparam logic [7:0] ECT_IDX_B_MU_HI = 8'h3b;

  // power-up values of the parameter bytes
  localparam logic [7:0] ECT_RST_DT_LO = 8'h00;
  localparam logic [7:0] ECT_RST_DT_HI = 8'h48;
  localparam logic [7:0] ECT_RST_SUP_LO = 8'h60;
  localparam logic [7:0] ECT_RST_SUP_HI = 8'h0b;
  localparam logic [7:0] ECT_RST_MU_LO = 8'h00;
  localparam logic [7:0] ECT_RST_MU_HI = 8'h40;

  // whole-value defaults and limits
  localparam logic [15:0] ECT_DT_DEFAULT = 16'h4800;
  localparam logic [15:0] ECT_SUP_DEFAULT = 16'h0b60;
  localparam logic [15:0] ECT_MU_DEFAULT = 16'h4000;
  localparam logic [15:0] ECT_DT_MAX = 16'h7fff;

  // slot numbers in the byte bank
  localparam int ECT_NREG = 12;
  localparam logic [3:0] ECT_SLOT_NONE = 4'hf;
  localparam logic [3:0] ECT_SLOT_A_DT_HI = 4'h1;
  localparam logic [3:0] ECT_SLOT_B_DT_HI = 4'h7;

  localparam logic [7:0] ECT_REG_IDX [ECT_NREG] = '{
    ECT_IDX_A_DT_LO, ECT_IDX_A_DT_HI, ECT_IDX_A_SUP_LO, ECT_IDX_A_SUP_HI,
    ECT_IDX_A_MU_LO, ECT_IDX_A_MU_HI, ECT_IDX_B_DT_LO, ECT_IDX_B_DT_HI,
    ECT_IDX_B_SUP_LO, ECT_IDX_B_SUP_HI, ECT_IDX_B_MU_LO, ECT_IDX_B_MU_HI};
  localparam logic [7:0] ECT_REG_RST [ECT_NREG] = '{
    ECT_RST_DT_LO, ECT_RST_DT_HI, ECT_RST_SUP_LO, ECT_RST_SUP_HI,
    ECT_RST_MU_LO, ECT_RST_MU_HI, ECT_RST_DT_LO, ECT_RST_DT_HI,
    ECT_RST_SUP_LO, ECT_RST_SUP_HI, ECT_RST_MU_LO, ECT_RST_MU_HI};

  // bus responses
  localparam logic [1:0] ECT_RESP_OKAY = 2'b00;
  localparam logic [1:0] ECT_RESP_SLVERR = 2'b10;

endpackage

// file: core/ect_byte_reg.sv
// one byte-wide tuning parameter register
// assumes a single write enable pulse from the bus slave
`timescale 1ns/1ps
module ect_byte_reg
  import ect_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter bit TOP_CLR = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] value
);

  logic [7:0] next_value;

  // clearing bit 7 keeps a 16-bit value at or below its maximum
  assign next_value = wrEn ? {wrData[7] & ~TOP_CLR, wrData[6:0]} : value;

  // value holds until rewritten or reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      value <= RST_VAL;
    end else begin
      value <= next_value;
    end
  end

endmodule

// file: core/ect_chan_hold.sv
// one-deep holding stage for an AXI4-Lite request channel
// assumes release is asserted only while the stage is full
`timescale 1ns/1ps
module ect_chan_hold
  import ect_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic valid,
  output logic ready,
  input wire logic [W-1:0] payload,
  output logic full,
  output logic [W-1:0] data,
  input wire logic release_
);

  logic take;
  logic next_full;

  // a beat is taken when the source is valid and ready is high; ready stays low in the first cycle after reset
  assign take = valid & ready;
  assign next_full = (full & ~release_) | take;

  // ready comes from a flop and drops as soon as the stage fills
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      full <= 1'b0;
      ready <= 1'b0;
      data <= '0;
    end else begin
      full <= next_full;
      ready <= ~next_full;
      if (take) begin
        data <= payload;
      end
    end
  end

endmodule

// file: core/ect_tuning_regs.sv
// tuning register bank for two echo cancellers, behind AXI4-Lite
// assumes a master that keeps one write and one read in flight at most
`timescale 1ns/1ps
module ect_tuning_regs
  import ect_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] dtThreshA,
  output logic [15:0] supThreshA,
  output logic [15:0] stepSizeA,
  output logic [15:0] dtThreshB,
  output logic [15:0] supThreshB,
  output logic [15:0] stepSizeB
);

  // map a byte address to a bank slot, or to no slot
  function automatic logic [3:0] regSlot(input logic [ADDR_W-1:0] addr);
    logic [3:0] slot;
    slot = ECT_SLOT_NONE;
    for (int i = 0; i < ECT_NREG; i++) begin
      if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] == ECT_REG_IDX[i][5:0]) begin
        slot = 4'(i);
      end
    end
    return slot;
  endfunction

  logic awFull;
  logic [ADDR_W-1:0] awHeld;
  logic wFull;
  logic [8:0] wHeld;
  logic arFull;
  logic [ADDR_W-1:0] arHeld;
  logic doWrite;
  logic doRead;
  logic [3:0] wrSlot;
  logic [3:0] rdSlot;
  logic wrHit;
  logic rdHit;
  logic wrLane0;
  logic [7:0] regVal [ECT_NREG];
  logic [7:0] rdByte;
  logic [1:0] next_bresp;
  logic [1:0] next_rresp;

  // request stages for write address, write data and read address
  ect_chan_hold #(.W(ADDR_W)) awStage (
    .clk(clk),
    .reset(reset),
    .valid(awvalid),
    .ready(awready),
    .payload(awaddr),
    .full(awFull),
    .data(awHeld),
    .release_(doWrite)
  );

  ect_chan_hold #(.W(9)) wStage (
    .clk(clk),
    .reset(reset),
    .valid(wvalid),
    .ready(wready),
    .payload({wstrb[0], wdata[7:0]}),
    .full(wFull),
    .data(wHeld),
    .release_(doWrite)
  );

  ect_chan_hold #(.W(ADDR_W)) arStage (
    .clk(clk),
    .reset(reset),
    .valid(arvalid),
    .ready(arready),
    .payload(araddr),
    .full(arFull),
    .data(arHeld),
    .release_(doRead)
  );

  // a write completes once address and data are both held
  assign doWrite = awFull & wFull & ~bvalid;
  assign doRead = arFull & ~rvalid;
  assign wrSlot = regSlot(awHeld);
  assign rdSlot = regSlot(arHeld);
  assign wrHit = wrSlot != ECT_SLOT_NONE;
  assign rdHit = rdSlot != ECT_SLOT_NONE;
  assign wrLane0 = wHeld[8]; // only byte lane 0 carries register data

  // parameter byte bank, one register per slot
  for (genvar g = 0; g < ECT_NREG; g++) begin : gBank
    ect_byte_reg #(
      .RST_VAL(ECT_REG_RST[g]),
      .TOP_CLR(g == ECT_SLOT_A_DT_HI || g == ECT_SLOT_B_DT_HI)
    ) byteReg (
      .clk(clk),
      .reset(reset),
      .wrEn(doWrite & wrLane0 & (wrSlot == 4'(g))),
      .wrData(wHeld[7:0]),
      .value(regVal[g])
    );
  end

  // high byte in the second register, low byte in the first
  assign dtThreshA = {regVal[1], regVal[0]};
  assign supThreshA = {regVal[3], regVal[2]};
  assign stepSizeA = {regVal[5], regVal[4]};
  assign dtThreshB = {regVal[7], regVal[6]};
  assign supThreshB = {regVal[9], regVal[8]};
  assign stepSizeB = {regVal[11], regVal[10]};

  // read selection and responses; unmapped addresses answer slave error
  assign rdByte = rdHit ? regVal[rdSlot] : 8'h00;
  assign next_bresp = wrHit ? ECT_RESP_OKAY : ECT_RESP_SLVERR;
  assign next_rresp = rdHit ? ECT_RESP_OKAY : ECT_RESP_SLVERR;

  // write response channel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= ECT_RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= next_bresp;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data channel; upper bits read as zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rresp <= ECT_RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else if (doRead) begin
      rvalid <= 1'b1;
      rresp <= next_rresp;
      rdata <= {24'h00_0000, rdByte};
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks on the parameter bank
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic wrAHi;
  logic wrALo;
  logic wrSupLo;
  logic wrAnyA;
  logic rdAMuHi;
  logic rdBMuLo;

  assign wrAHi = doWrite & wrLane0 & (wrSlot == 4'h5);
  assign wrALo = doWrite & wrLane0 & (wrSlot == 4'h4);
  assign wrSupLo = doWrite & wrLane0 & (wrSlot == 4'h2);
  assign wrAnyA = doWrite & wrLane0 & (wrSlot < 4'h6);
  assign rdAMuHi = arvalid & arready
    & (araddr == ADDR_W'({ECT_IDX_A_MU_HI, 2'b00}));
  assign rdBMuLo = arvalid & arready
    & (araddr == ADDR_W'({ECT_IDX_B_MU_LO, 2'b00}));

  sequence sAnswerAHi;
    ##2 rvalid && rdata[7:0] == stepSizeA[15:8];
  endsequence

  sequence sAnswerBLo;
    ##2 rvalid && rdata[7:0] == stepSizeB[7:0];
  endsequence

  a_dt_reset_value: assert property (
    $fell(reset) |-> dtThreshA == ECT_DT_DEFAULT
      && dtThreshB == ECT_DT_DEFAULT)
    else $error("double-talk threshold not at default after reset");

  a_dt_max_held: assert property (
    dtThreshA <= ECT_DT_MAX && dtThreshB <= ECT_DT_MAX)
    else $error("double-talk threshold above its maximum");

  a_sup_reset_value: assert property (
    $fell(reset) |-> supThreshA == ECT_SUP_DEFAULT
      && supThreshB == ECT_SUP_DEFAULT)
    else $error("suppressor threshold not at default after reset");

  a_sup_low_byte: assert property (
    wrSupLo |=> supThreshA[7:0] == $past(wHeld[7:0])
      && $stable(supThreshA[15:8]))
    else $error("suppressor low byte write went astray");

  a_mu_sign_kept: assert property (
    wrAHi && wHeld[7] |=> $signed(stepSizeA) < 0)
    else $error("negative step size not kept");

  a_mu_reset_value: assert property (
    $fell(reset) |-> stepSizeA == ECT_MU_DEFAULT
      && stepSizeB == ECT_MU_DEFAULT)
    else $error("step size not at default after reset");

  a_mu_a_read: assert property (
    rdAMuHi && !rvalid && !doWrite |-> sAnswerAHi)
    else $error("canceller A step size high byte misread");

  a_mu_b_read: assert property (
    rdBMuLo && !rvalid && !doWrite |-> sAnswerBLo)
    else $error("canceller B step size low byte misread");

  a_mu_b_apart: assert property (
    wrAnyA |=> $stable(stepSizeB) && $stable(dtThreshB))
    else $error("write to canceller A disturbed canceller B");

  a_mu_high_byte: assert property (
    wrAHi |=> stepSizeA[15:8] == $past(wHeld[7:0])
      && $stable(stepSizeA[7:0]))
    else $error("step size high byte not in upper bits");

  a_mu_low_byte: assert property (
    wrALo |=> stepSizeA[7:0] == $past(wHeld[7:0]))
    else $error("step size low byte not in lower bits");

  a_bank_holds: assert property (
    !doWrite |=> $stable(stepSizeA) && $stable(supThreshB)
      && $stable(dtThreshA) && $stable(stepSizeB))
    else $error("parameter changed without a write");

  a_write_answer: assert property (
    doWrite |=> bvalid)
    else $error("write response missing");

  a_read_answer: assert property (
    doRead |=> rvalid && rdata[31:8] == 24'h00_0000)
    else $error("read data missing or upper bits not zero");

  a_bvalid_clear: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response not cleared after acceptance");

  a_rvalid_clear: assert property (
    rvalid && rready |=> !rvalid)
    else $error("read data not cleared after acceptance");

  a_write_error: assert property (
    doWrite && !wrHit |=> bvalid && bresp == ECT_RESP_SLVERR)
    else $error("unmapped write not answered with slave error");

  a_read_error: assert property (
    doRead && !rdHit |=> rvalid && rresp == ECT_RESP_SLVERR
      && rdata == 32'h0000_0000)
    else $error("unmapped read not answered with slave error");

  a_dt_a_clamp: assert property (
    doWrite && wrLane0 && wrSlot == 4'h1 |=> dtThreshA[15:8]
      == {1'b0, $past(wHeld[6:0])} && $stable(dtThreshA[7:0]))
    else $error("double-talk high byte of canceller A not clamped");

  a_dt_b_clamp: assert property (
    doWrite && wrLane0 && wrSlot == 4'h7 |=> dtThreshB[15:8]
      == {1'b0, $past(wHeld[6:0])} && $stable(dtThreshB[7:0]))
    else $error("double-talk high byte of canceller B not clamped");

  a_dt_low_byte: assert property (
    doWrite && wrLane0 && wrSlot == 4'h0 |=> dtThreshA[7:0]
      == $past(wHeld[7:0]) && $stable(dtThreshA[15:8]))
    else $error("double-talk low byte write went astray");

  a_sup_high_byte: assert property (
    doWrite && wrLane0 && wrSlot == 4'h9 |=> supThreshB[15:8]
      == $past(wHeld[7:0]) && $stable(supThreshB[7:0]))
    else $error("suppressor high byte write went astray");

  a_mu_b_high: assert property (
    doWrite && wrLane0 && wrSlot == 4'hb |=> stepSizeB[15:8]
      == $past(wHeld[7:0]) && $stable(stepSizeB[7:0]))
    else $error("step size B high byte not in upper bits");

  a_mu_a_apart: assert property (
    doWrite && wrLane0 && wrHit && wrSlot > 4'h5 |=> $stable(stepSizeA)
      && $stable(dtThreshA) && $stable(supThreshA))
    else $error("write to canceller B disturbed canceller A");

  a_refused_hold: assert property (
    doWrite && !(wrLane0 && wrHit) |=> $stable(stepSizeA)
      && $stable(stepSizeB) && $stable(dtThreshA) && $stable(dtThreshB)
      && $stable(supThreshA) && $stable(supThreshB))
    else $error("refused write changed a parameter");

endmodule

// file: testbench/tb_ect_tuning_regs.sv
// self-checking bench for the tuning register bank, AXI4-Lite master tasks
// assumes the bank answers every request within a few cycles
`timescale 1ns/1ps
module tb_ect_tuning_regs;
  import ect_pkg::*;

  localparam logic [1:0] OKR = ECT_RESP_OKAY;
  localparam logic [1:0] ERR = ECT_RESP_SLVERR;
  localparam logic [15:0] DTD = 16'h4800;
  localparam logic [15:0] SPD = 16'h0b60;
  localparam logic [15:0] STD = 16'h4000;
  localparam logic [15:0] MAXV = 16'h7fff;

  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] dtA, supA, stA, dtB, supB, stB;
  int miscompares = 0;
  int checks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ect_tuning_regs #(.ADDR_W(8)) ect_tuning_regs_inst (
    .clk(clk), .reset(reset),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dtThreshA(dtA), .supThreshA(supA), .stepSizeA(stA),
    .dtThreshB(dtB), .supThreshB(supB), .stepSizeB(stB)
  );

  // byte address of a register index
  function automatic logic [7:0] ad(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one write; address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  // one read; data and response taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] ev,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(rdata, ev);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // compare all six parameter outputs
  task automatic outs(input logic [15:0] a0, a1, a2, b0, b1, b2);
    chk({dtA, dtB}, {a0, b0});
    chk({supA, supB}, {a1, b1});
    chk({stA, stB}, {a2, b2});
  endtask

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    for (int i = 0; i < ECT_NREG; i++) begin
      rd(ad(ECT_REG_IDX[i]), {24'h0, ECT_REG_RST[i]}, OKR);
    end
    outs(DTD, SPD, STD, DTD, SPD, STD);
    // negative step size on A, largest legal one on B
    wr(ad(ECT_IDX_A_MU_LO), 8'h34, 4'h1, OKR);
    wr(ad(ECT_IDX_A_MU_HI), 8'h92, 4'h1, OKR);
    outs(DTD, SPD, 16'h9234, DTD, SPD, STD);
    wr(ad(ECT_IDX_B_MU_LO), 8'hff, 4'h1, OKR);
    wr(ad(ECT_IDX_B_MU_HI), 8'h7f, 4'h1, OKR);
    outs(DTD, SPD, 16'h9234, DTD, SPD, MAXV);
    rd(ad(ECT_IDX_A_MU_HI), 32'h92, OKR);
    rd(ad(ECT_IDX_A_MU_LO), 32'h34, OKR);
    rd(ad(ECT_IDX_B_MU_HI), 32'h7f, OKR);
    rd(ad(ECT_IDX_B_MU_LO), 32'hff, OKR);
    // double-talk threshold cannot pass its maximum
    wr(ad(ECT_IDX_A_DT_HI), 8'hff, 4'h1, OKR);
    wr(ad(ECT_IDX_A_DT_LO), 8'hff, 4'h1, OKR);
    rd(ad(ECT_IDX_A_DT_HI), 32'h7f, OKR);
    wr(ad(ECT_IDX_B_DT_HI), 8'hff, 4'h1, OKR);
    rd(ad(ECT_IDX_B_DT_HI), 32'h7f, OKR);
    wr(ad(ECT_IDX_B_SUP_HI), 8'hff, 4'h1, OKR);
    wr(ad(ECT_IDX_B_SUP_LO), 8'h01, 4'h1, OKR);
    wr(ad(ECT_IDX_A_SUP_LO), 8'h5a, 4'h1, OKR);
    outs(MAXV, 16'h0b5a, 16'h9234, 16'h7f00, 16'hff01, MAXV);
    // refused stores leave every byte alone
    wr(ad(ECT_IDX_A_MU_HI), 8'h11, 4'h0, OKR);
    wr(8'h00, 8'h55, 4'h1, ERR);
    wr(ad(ECT_IDX_A_MU_LO) | 8'h01, 8'h66, 4'h1, ERR);
    rd(8'h00, 32'h0, ERR);
    outs(MAXV, 16'h0b5a, 16'h9234, 16'h7f00, 16'hff01, MAXV);
    // reset in mid-run restores the defaults
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    outs(DTD, SPD, STD, DTD, SPD, STD);
    rd(ad(ECT_IDX_B_MU_HI), 32'h40, OKR);
    end_sim;
  end

  // watchdog cuts a hung handshake short
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule
